// >>> inc/abf_pkg.sv
package abf_pkg;

  // ------------------------------------------------------------
  // register indices: the byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [11:0] ABF_IDX_RATE  = 12'h500; // bit-clock rate code
  localparam logic [11:0] ABF_IDX_FLEN  = 12'h506; // frame length divider
  localparam logic [11:0] ABF_IDX_CFG   = 12'h510; // mode, selectors
  localparam logic [11:0] ABF_IDX_CHEN  = 12'h519; // channel enables
  localparam logic [11:0] ABF_IDX_STAT  = 12'h520; // live status
  localparam int          ABF_AW        = 14;

  // ------------------------------------------------------------
  // reset values and field limits
  // ------------------------------------------------------------
  localparam logic [4:0]  ABF_RATE_RST  = 5'h0c;
  localparam logic [12:0] ABF_FLEN_RST  = 13'h0040;
  localparam logic [12:0] ABF_FLEN_MIN  = 13'h0008;
  localparam logic [3:0]  ABF_SEL_ASYNC = 4'h8;   // selector 1000
  localparam logic [1:0]  ABF_FAM44     = 2'h1;   // sample rate 01xxx
  localparam logic [1:0]  ABF_RESP_OK   = 2'h0;
  localparam logic [1:0]  ABF_RESP_ERR  = 2'h2;

  // ------------------------------------------------------------
  // reference clock behind the rate table steps
  // (each entry is the step added to a 32-bit phase accumulator
  // clocked from a 50 MHz reference: step = f * 2^32 / 50e6)
  // ------------------------------------------------------------
  localparam int unsigned ABF_REF_HZ = 50_000_000;

  typedef struct packed {
    logic [4:0]  rate;     // bit-clock rate code
    logic [12:0] flen;     // frame length divider
    logic        master;   // 1 = device drives clocks
    logic [3:0]  sel;      // interface rate selector
    logic [4:0]  sys_sr;   // system sample rate setting
    logic [4:0]  async_sr; // async sample rate setting
  } abf_cfg_t;

endpackage : abf_pkg

// >>> core/abf_frame_div.sv
// divides bit-clock edges into frame clock
module abf_frame_div
  import abf_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // control
  input  wire logic        run,
  input  wire logic        bit_fall,
  input  wire logic [12:0] flen,
  // output
  output logic             frame_clk
);

  logic [12:0] cnt_r, cnt_nxt;     // bit clocks into frame
  logic        frm_r, frm_nxt;     // frame clock level

  // ------------------------------------------------------------
  // next state: first half of frame high, rest low
  // ------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    frm_nxt = frm_r;
    if (!run) begin
      cnt_nxt = '0;
      frm_nxt = 1'b0;
    end else if (bit_fall) begin
      if (cnt_r >= flen - 13'h0001) begin
        cnt_nxt = '0;
      end else begin
        cnt_nxt = cnt_r + 13'h0001;
      end
      frm_nxt = (cnt_nxt < {1'b0, flen[12:1]});
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      frm_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      frm_r <= frm_nxt;
    end
  end

  assign frame_clk = frm_r;

endmodule : abf_frame_div

// >>> core/abf_rate_gen.sv
// Contract
// - rate code picks bit clock, family chooses
// - selector below 1000 uses system domain
// - selector 1000 up uses async domain
// - frame clock is bit clock over divider
// - frame clock derives only from bit clock in master mode; slave mode passes the frame pin through
// - rate code locked while channels enabled
// - code 00010 gives 64k or 58.8k
// - code 10001 gives 12.288M or 11.2896M
// - code 10010 gives 24.576M or 22.5792M
// - 44.1k family only for 01xxx setting
module abf_rate_gen
  import abf_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [13:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [13:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // interface clock pins
  input  wire logic        bit_clk_in,
  output logic             bit_clk_out,
  output logic             bit_clk_oe,
  input  wire logic        frame_clk_in,
  output logic             frame_clk_out,
  output logic             frame_clk_oe,
  // status
  output logic             family44
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  abf_cfg_t    cfg_r, cfg_nxt;       // software configuration
  logic [15:0] chen_r, chen_nxt;     // tx/rx channel enables
  logic        aw_hold_r, aw_hold_nxt; // write address taken
  logic [13:0] aw_addr_r, aw_addr_nxt;
  logic        w_hold_r, w_hold_nxt;   // write data taken
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0]  w_strb_r, w_strb_nxt;
  logic        bv_r, bv_nxt;
  logic [1:0]  br_r, br_nxt;
  logic        rv_r, rv_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [1:0]  rr_r, rr_nxt;
  logic [31:0] ph_r, ph_nxt;         // bit-clock phase accumulator
  logic        bclk_r, bclk_nxt;     // generated bit clock
  logic        fam_r, fam_nxt;       // registered family flag
  logic [1:0]  bsync_r, fsync_r;     // pin synchronisers
  logic        bprev_r;              // synchronised bit clock, old
  logic        frame_gen;            // divider output
  logic        bit_fall;             // falling edge of active bclk
  logic        any_en;               // some channel enabled
  logic        fam44;                // 44.1 kHz family selected
  logic [4:0]  gov_sr;               // governing sample rate
  logic [31:0] step;                 // accumulator step
  logic        wr_go, rd_go;
  logic [31:0] wmask;
  logic        awr_r, awr_nxt;       // aw/w ready, registered
  logic        arr_r, arr_nxt;       // read address ready pulse
  logic        fout_r, fout_nxt;     // frame clock output flop

  // ------------------------------------------------------------
  // rate table: accumulator step = f * 2^32 / 50 MHz
  // codes without a frequency give zero, so no clock runs
  // ------------------------------------------------------------
  function automatic logic [31:0] rate_step(input logic [4:0] code,
                                            input logic       f44);
    logic [31:0] s48;
    logic [31:0] s44;
    s48 = 32'h0000_0000;
    s44 = 32'h0000_0000;
    case (code)
      5'h02: begin s48 = 32'h0053_e2d6; s44 = 32'h004d_1221; end
      5'h03: begin s48 = 32'h007d_d441; s44 = 32'h0073_9b32; end
      5'h04: begin s48 = 32'h00a7_c5ac; s44 = 32'h009a_2443; end
      5'h05: begin s48 = 32'h00fb_a882; s44 = 32'h00e7_3664; end
      5'h06: begin s48 = 32'h014f_8b58; s44 = 32'h0134_4886; end
      5'h07: begin s48 = 32'h01f7_5104; s44 = 32'h01ce_6cc9; end
      5'h08: begin s48 = 32'h029f_16b1; s44 = 32'h0268_910c; end
      5'h09: begin s48 = 32'h03ee_a209; s44 = 32'h039c_d992; end
      5'h0a: begin s48 = 32'h053e_2d62; s44 = 32'h04d1_2218; end
      5'h0b: begin s48 = 32'h07dd_4413; s44 = 32'h0739_b324; end
      5'h0c: begin s48 = 32'h0a7c_5ac4; s44 = 32'h09a2_4430; end
      5'h0d: begin s48 = 32'h0fba_8826; s44 = 32'h0e73_6648; end
      5'h0e: begin s48 = 32'h14f8_b589; s44 = 32'h1344_8861; end
      5'h0f: begin s48 = 32'h1f75_104d; s44 = 32'h1ce6_cc92; end
      5'h10: begin s48 = 32'h29f1_6b12; s44 = 32'h2689_10c2; end
      5'h11: begin s48 = 32'h3eea_209a; s44 = 32'h39cd_9923; end
      5'h12: begin s48 = 32'h7dd4_4135; s44 = 32'h739b_3246; end
      default: begin s48 = 32'h0000_0000; s44 = 32'h0000_0000; end
    endcase
    rate_step = f44 ? s44 : s48;
  endfunction : rate_step

  // ------------------------------------------------------------
  // family selection from governing domain
  // ------------------------------------------------------------
  always_comb begin
    any_en = |chen_r;
    if (cfg_r.sel < ABF_SEL_ASYNC) begin
      gov_sr = cfg_r.sys_sr;
    end else begin
      gov_sr = cfg_r.async_sr;
    end
    fam44 = (gov_sr[4:3] == ABF_FAM44);
    step  = rate_step(cfg_r.rate, fam_r);
  end

  // ------------------------------------------------------------
  // axi4-lite slave: aw and w in either order, one at a time
  // ------------------------------------------------------------
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_hold_nxt  = w_hold_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bv_nxt      = bv_r;
    br_nxt      = br_r;
    rv_nxt      = rv_r;
    rd_nxt      = rd_r;
    rr_nxt      = rr_r;
    cfg_nxt     = cfg_r;
    chen_nxt    = chen_r;
    wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
             {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    if (s_axi_awvalid && !aw_hold_r && !bv_r) begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_r && !bv_r) begin
      w_hold_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    wr_go = aw_hold_r && w_hold_r && !bv_r;
    if (wr_go) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bv_nxt      = 1'b1;
      br_nxt      = ABF_RESP_OK;
      case (aw_addr_r[13:2])
        ABF_IDX_RATE: begin
          if (!any_en && w_strb_r[0]) begin
            cfg_nxt.rate = w_data_r[4:0];
          end
        end
        ABF_IDX_FLEN: begin
          cfg_nxt.flen = (cfg_r.flen & ~wmask[12:0]) |
                         (w_data_r[12:0] & wmask[12:0]);
        end
        ABF_IDX_CFG: begin
          if (w_strb_r[0]) begin
            cfg_nxt.master = w_data_r[0];
            cfg_nxt.sel    = w_data_r[7:4];
          end
          if (w_strb_r[1]) cfg_nxt.sys_sr   = w_data_r[12:8];
          if (w_strb_r[2]) cfg_nxt.async_sr = w_data_r[20:16];
        end
        ABF_IDX_CHEN: begin
          chen_nxt = (chen_r & ~wmask[15:0]) |
                     (w_data_r[15:0] & wmask[15:0]);
        end
        ABF_IDX_STAT: begin
          br_nxt = ABF_RESP_OK;  // read-only, write ignored
        end
        default: br_nxt = ABF_RESP_ERR;
      endcase
    end
    if (bv_r && s_axi_bready) begin
      bv_nxt = 1'b0;
    end
    rd_go = s_axi_arvalid && !rv_r;
    if (rd_go) begin
      rv_nxt = 1'b1;
      rr_nxt = ABF_RESP_OK;
      case (s_axi_araddr[13:2])
        ABF_IDX_RATE: rd_nxt = {27'h0, cfg_r.rate};
        ABF_IDX_FLEN: rd_nxt = {19'h0, cfg_r.flen};
        ABF_IDX_CFG:  rd_nxt = {11'h0, cfg_r.async_sr, 3'h0,
                                cfg_r.sys_sr, cfg_r.sel, 3'h0,
                                cfg_r.master};
        ABF_IDX_CHEN: rd_nxt = {16'h0, chen_r};
        ABF_IDX_STAT: rd_nxt = {28'h0, frame_clk_out, bclk_r,
                                any_en, fam_r};
        default: begin
          rd_nxt = 32'h0;
          rr_nxt = ABF_RESP_ERR;
        end
      endcase
    end else if (rv_r && s_axi_rready) begin
      rv_nxt = 1'b0;
    end
    // ready flags as flops, equal to what the held state implies
    awr_nxt = aw_hold_nxt && w_hold_nxt && !bv_nxt;
    arr_nxt = rd_go;
  end

  // ------------------------------------------------------------
  // bit clock generation (master) and edge detect (both)
  // limitation: generated clock jitters by one 20 ns cycle
  // ------------------------------------------------------------
  always_comb begin
    fam_nxt = fam44;
    ph_nxt  = ph_r;
    bclk_nxt = bclk_r;
    if (cfg_r.master && any_en && (step != 32'h0)) begin
      ph_nxt   = ph_r + step;
      bclk_nxt = ph_r[31];
    end else begin
      ph_nxt   = 32'h0;
      bclk_nxt = 1'b0;
    end
    bit_fall = cfg_r.master ? (bclk_r && !bclk_nxt)
                            : (bprev_r && !bsync_r[1]);
    fout_nxt = cfg_r.master ? frame_gen : fsync_r[1];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r     <= '{rate: ABF_RATE_RST, flen: ABF_FLEN_RST,
                     master: 1'b0, sel: 4'h0, sys_sr: 5'h0,
                     async_sr: 5'h0};
      chen_r    <= 16'h0;
      aw_hold_r <= 1'b0;
      aw_addr_r <= 14'h0;
      w_hold_r  <= 1'b0;
      w_data_r  <= 32'h0;
      w_strb_r  <= 4'h0;
      bv_r      <= 1'b0;
      br_r      <= ABF_RESP_OK;
      rv_r      <= 1'b0;
      rd_r      <= 32'h0;
      rr_r      <= ABF_RESP_OK;
      ph_r      <= 32'h0;
      bclk_r    <= 1'b0;
      fam_r     <= 1'b0;
      bsync_r   <= 2'h0;
      fsync_r   <= 2'h0;
      bprev_r   <= 1'b0;
      awr_r     <= 1'b0;
      arr_r     <= 1'b0;
      fout_r    <= 1'b0;
    end else begin
      cfg_r     <= cfg_nxt;
      chen_r    <= chen_nxt;
      aw_hold_r <= aw_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_hold_r  <= w_hold_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bv_r      <= bv_nxt;
      br_r      <= br_nxt;
      rv_r      <= rv_nxt;
      rd_r      <= rd_nxt;
      rr_r      <= rr_nxt;
      ph_r      <= ph_nxt;
      bclk_r    <= bclk_nxt;
      fam_r     <= fam_nxt;
      bsync_r   <= {bsync_r[0], bit_clk_in};
      fsync_r   <= {fsync_r[0], frame_clk_in};
      bprev_r   <= bsync_r[1];
      awr_r     <= awr_nxt;
      arr_r     <= arr_nxt;
      fout_r    <= fout_nxt;
    end
  end

  // ------------------------------------------------------------
  // frame divider, fed only by bit-clock edges
  // ------------------------------------------------------------
  abf_frame_div u_div (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .run       (cfg_r.master && any_en &&
                (cfg_r.flen >= ABF_FLEN_MIN)),
    .bit_fall  (bit_fall),
    .flen      (cfg_r.flen),
    .frame_clk (frame_gen)
  );

  // ------------------------------------------------------------
  // outputs, all from flip-flops
  // ------------------------------------------------------------
  assign s_axi_awready = awr_r;
  assign s_axi_wready  = awr_r;
  assign s_axi_bvalid  = bv_r;
  assign s_axi_bresp   = br_r;
  assign s_axi_arready = arr_r;
  assign s_axi_rvalid  = rv_r;
  assign s_axi_rdata   = rd_r;
  assign s_axi_rresp   = rr_r;
  assign bit_clk_out   = bclk_r;
  assign bit_clk_oe    = cfg_r.master;
  assign frame_clk_out = fout_r;
  assign frame_clk_oe  = cfg_r.master;
  assign family44      = fam_r;

endmodule : abf_rate_gen

// >>> test/abf_rate_gen_asserts.sv
module abf_rate_gen_asserts
  import abf_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // link pins and status
  input wire logic frame_clk_in,
  input wire logic bit_clk_oe,
  input wire logic frame_clk_out,
  input wire logic frame_clk_oe,
  input wire logic family44
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------
  // link direction
  // ----------------------------------------------
  a_oe_pair: assert property (bit_clk_oe == frame_clk_oe)
    else $error("clock enables disagree");
  // slave frame is the two-flop copy of the pin, then the output flop
  a_slave_follow: assert property ($past(!bit_clk_oe)
    |-> frame_clk_out == $past(frame_clk_in, 3))
    else $error("slave frame not passed through");
  a_reset_quiet: assert property ($rose(aresetn)
    |-> !s_axi_bvalid && !s_axi_rvalid && !bit_clk_oe)
    else $error("outputs active after reset");
  // family flag moves only two edges after a write
  a_fam_write: assert property ($changed(family44)
    |-> $past(s_axi_awready, 2))
    else $error("family changed without write");
  // ----------------------------------------------
  // register bus answers
  // ----------------------------------------------
  a_write_answer: assert property (s_axi_awready && s_axi_awvalid
    |=> s_axi_bvalid)
    else $error("no write response after handshake");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid
    |=> s_axi_rvalid)
    else $error("no read data after request");
  a_arready_done: assert property (s_axi_arready
    |-> s_axi_rvalid && !$past(s_axi_rvalid))
    else $error("address ready outside first data cycle");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid)
    else $error("read data dropped before taken");
  a_ready_pair: assert property (s_axi_awready == s_axi_wready)
    else $error("address and data ready split");
endmodule : abf_rate_gen_asserts

bind abf_rate_gen abf_rate_gen_asserts chk_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .frame_clk_in(frame_clk_in),
  .bit_clk_oe(bit_clk_oe), .frame_clk_out(frame_clk_out),
  .frame_clk_oe(frame_clk_oe), .family44(family44)
);

// >>> test/abf_codec_model.sv
module abf_codec_model #(
  parameter int HALF = 4, // aclk cycles per bit-clock half
  parameter int FL   = 16 // bit clocks per frame
) (
  // clock
  input  wire logic aclk,
  // link side
  input  wire logic run,
  output logic      bclk,
  output logic      frame
);
  timeunit 1ns;
  timeprecision 1ns;
  int ph = 0; // half-period count
  int bn = 0; // bit index in frame
  // ----------------------------------------------
  // far-side clock master, both clocks held low while run is low
  // ----------------------------------------------
  always @(posedge aclk) begin
    if (!run) begin
      bclk  <= 1'h0;
      frame <= 1'h0;
      ph    <= 0;
      bn    <= 0;
    end else if (ph == HALF - 1) begin
      ph   <= 0;
      bclk <= !bclk;
      // frame moves on falling bit edges only
      if (bclk) begin
        bn    <= (bn + 1) % FL;
        frame <= (bn + 1) % FL < FL / 2;
      end
    end else begin
      ph <= ph + 1;
    end
  end
endmodule : abf_codec_model

// >>> test/tb_top.sv
module tb_top
  import abf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------
  // design pins
  // ----------------------------------------------
  logic        aclk = '0, aresetn = '0;
  logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = '0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic        s_axi_arvalid = '0, s_axi_rready = '0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, family44;
  logic        bit_clk_out, bit_clk_oe, frame_clk_out, frame_clk_oe;
  logic        p_bclk, p_frame, p_run = '0; // far side
  // shared wire: the enabled party drives it
  wire logic   bit_clk_in   = bit_clk_oe ? bit_clk_out : p_bclk;
  wire logic   frame_clk_in = frame_clk_oe ? frame_clk_out : p_frame;
  // ----------------------------------------------
  // reference model and counters
  // ----------------------------------------------
  logic [31:0] m[logic [11:0]]; // register mirror
  int          errors = 0;
  int          checks_done = 0;
  int          f48[3] = '{64000, 12288000, 24576000};
  int          f44[3] = '{58800, 11289600, 22579200};
  initial begin
    forever #10 aclk = ~aclk;
  end
  abf_rate_gen dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .bit_clk_in(bit_clk_in),
    .bit_clk_out(bit_clk_out), .bit_clk_oe(bit_clk_oe),
    .frame_clk_in(frame_clk_in), .frame_clk_out(frame_clk_out),
    .frame_clk_oe(frame_clk_oe), .family44(family44)
  );
  abf_codec_model far (.aclk(aclk), .run(p_run), .bclk(p_bclk),
                       .frame(p_frame));
  // ----------------------------------------------
  // helpers
  // ----------------------------------------------
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // selector bit 3 picks the async setting
  function automatic logic fam44(logic [31:0] c);
    logic [4:0] sr;
    sr = c[7] ? c[20:16] : c[12:8];
    return sr[4:3] == 2'h1;
  endfunction : fam44
  function automatic logic [31:0] msk(logic [11:0] ix);
    case (ix)
      ABF_IDX_RATE: return 32'h1f;
      ABF_IDX_FLEN: return 32'h1fff;
      ABF_IDX_CFG:  return 32'h1f1ff1;
      default:      return 32'hffff;
    endcase
  endfunction : msk
  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // counts of edges allow two of slack for start-up
  task automatic chk_cnt(string n, int e, int g);
    checks_done++;
    if (g < e - 2 || g > e + 2) begin
      errors++;
      $display("MISMATCH %s exp %0d got %0d", n, e, g);
    end
  endtask : chk_cnt
  task automatic wr(logic [11:0] ix, logic [31:0] d, logic [1:0] er);
    logic [1:0] r;
    bit         ok;
    ok = 0;
    @(posedge aclk);
    s_axi_awaddr  <= {ix, 2'h0};
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    for (int n = 0; n < 40 && !ok; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        ok = 1;
      end
    end
    if (!ok) begin
      errors++;
      results();
    end
    chk("bresp", er, r);
    // locked rate code keeps its old value
    if (er == ABF_RESP_OK && !(ix == ABF_IDX_RATE && m[ABF_IDX_CHEN] != 0))
      m[ix] = d & msk(ix);
    p_run <= m[ABF_IDX_CHEN] != 0 && !m[ABF_IDX_CFG][0];
  endtask : wr
  task automatic rdchk(logic [11:0] ix, logic [1:0] er);
    bit ok;
    ok = 0;
    @(posedge aclk);
    s_axi_araddr  <= {ix, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    for (int n = 0; n < 40 && !ok; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        chk("rresp", er, s_axi_rresp);
        chk("rdata", m.exists(ix) ? m[ix] : '0, s_axi_rdata);
        s_axi_rready <= 1'h0;
        ok = 1;
      end
    end
    if (!ok) begin
      errors++;
      results();
    end
  endtask : rdchk
  // counts rising edges of the two link clocks
  task automatic meas(int n, output int nb, output int nf);
    logic pb, pf;
    nb = 0;
    nf = 0;
    pb = bit_clk_in;
    pf = frame_clk_out;
    repeat (n) begin
      @(posedge aclk);
      nb += int'(bit_clk_in && !pb);
      nf += int'(frame_clk_out && !pf);
      pb = bit_clk_in;
      pf = frame_clk_out;
    end
  endtask : meas
  // ----------------------------------------------
  // main sequence
  // ----------------------------------------------
  initial begin
    int          nb, nf, k, fr, len;
    logic [15:0] s;
    s = 16'h004f;
    m[ABF_IDX_RATE] = 32'hc;
    m[ABF_IDX_FLEN] = 32'h40;
    m[ABF_IDX_CFG]  = '0;
    m[ABF_IDX_CHEN] = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (m[i]) rdchk(i, ABF_RESP_OK);
    // unmapped word in the map gap
    wr(12'h501, 32'h1, ABF_RESP_ERR);
    rdchk(12'h501, ABF_RESP_ERR);
    // random selectors and sample-rate settings, slave mode
    for (int i = 0; i < 12; i++) begin
      s = lfsr(lfsr(s));
      wr(ABF_IDX_CFG, 32'({s[15:11], 3'h0, s[10:6], s[5:2], 4'h0}),
         ABF_RESP_OK);
      // family flag is registered one edge after the cfg write lands
      @(posedge aclk);
      chk("family44", fam44(m[ABF_IDX_CFG]), family44);
    end
    // slave: far side makes the clocks, rate code locked
    wr(ABF_IDX_CHEN, 32'h100, ABF_RESP_OK);
    wr(ABF_IDX_RATE, 32'h5, ABF_RESP_OK);
    rdchk(ABF_IDX_RATE, ABF_RESP_OK);
    meas(2000, nb, nf);
    chk("bit_clk_oe", 1'h0, bit_clk_oe);
    chk_cnt("slave frames", 2000 / 128, nf);
    wr(ABF_IDX_CHEN, 32'h0, ABF_RESP_OK);
    wr(ABF_IDX_RATE, 32'h5, ABF_RESP_OK);
    rdchk(ABF_IDX_RATE, ABF_RESP_OK);
    // master: three codes in both families, frame lengths 8191, 8 and 11
    for (int i = 0; i < 6; i++) begin
      k   = i % 3;
      fr  = k == 0 ? 8191 : 5 + 3 * k;
      len = k == 0 ? 20000 : 1000;
      wr(ABF_IDX_CHEN, 32'h0, ABF_RESP_OK);
      wr(ABF_IDX_RATE, k == 0 ? 32'h2 : 32'h10 + k, ABF_RESP_OK);
      wr(ABF_IDX_FLEN, fr, ABF_RESP_OK);
      wr(ABF_IDX_CFG, i < 3 ? 32'h1 : 32'h90081, ABF_RESP_OK);
      wr(ABF_IDX_CHEN, 32'h1, ABF_RESP_OK);
      meas(len, nb, nf);
      chk("bit_clk_oe", 1'h1, bit_clk_oe);
      chk("family44", i >= 3, family44);
      chk_cnt("bclk",
              int'(longint'(i < 3 ? f48[k] : f44[k]) * len / 50000000),
              nb);
      chk_cnt("frames", nb / fr, nf);
    end
    results();
  end
endmodule : tb_top
